// [include/hvct_pkg.sv]
package hvct_pkg;

  // ==========================================================================
  // Register bus carrier
  // ==========================================================================
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } hvct_bus_req_t;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] ADDR_TMR_CTRL_BASE = 8'h50;
  localparam logic [7:0] ADDR_TMR_DUTY_BASE = 8'h51;
  localparam logic [7:0] ADDR_TMR_LAST      = 8'h57;
  localparam logic [7:0] ADDR_PIN_CTRL_BASE = 8'h60;
  localparam logic [7:0] ADDR_PIN_CTRL_LAST = 8'h67;
  localparam logic [7:0] ADDR_LIMP_HOME     = 8'h68;
  localparam logic [7:0] ADDR_TMR_STATUS    = 8'h69;
  localparam logic [7:0] ADDR_NV_UNLOCK     = 8'h70;
  localparam logic [7:0] ADDR_HS_FORCE_OFF  = 8'h71;
  localparam logic [7:0] ADDR_LS_FORCE_OFF  = 8'h72;

  localparam logic [7:0] NV_UNLOCK_KEY      = 8'ha5;
  localparam logic [7:0] FORCE_OFF_PRESET   = 8'h00;

  localparam int NUM_TIMERS = 4;
  localparam int NUM_PINS   = 8;

  // Timer control register fields.
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_PERIOD_LSB = 2;
  localparam int CTRL_WIDTH      = 6;

  // Pin control register fields.
  localparam int PIN_DRIVE_LSB   = 0;
  localparam int PIN_GATE_BIT    = 2;
  localparam int PIN_TSEL_LSB    = 3;
  localparam int PIN_CTRL_WIDTH  = 5;

  // Limp-home register fields and the pins they serve.
  localparam int LIMP_PIN3_BIT   = 0;
  localparam int LIMP_PIN4_BIT   = 1;
  localparam int LIMP3_PIN_IDX   = 2;
  localparam int LIMP4_PIN_IDX   = 3;
  localparam int LIMP3_TMR_IDX   = 2;
  localparam int LIMP4_TMR_IDX   = 3;

  typedef enum logic [1:0] {
    MODE_PWM      = 2'b00,
    MODE_TIMER    = 2'b01,
    MODE_SYNC     = 2'b10,
    MODE_FOLLOWER = 2'b11
  } hvct_mode_t;

  typedef enum logic [1:0] {
    DRIVE_OFF  = 2'b00,
    DRIVE_HIGH = 2'b01,
    DRIVE_LOW  = 2'b10,
    DRIVE_NONE = 2'b11
  } hvct_drive_t;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS   = 20;
  localparam int TICK_US         = 100;
  localparam int TICK_CYCLES_DEF = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS    = 1000 / TICK_US;
  localparam int PWM_FULL_SCALE  = 255;

  localparam int LIMP3_FREQ_CHZ  = 10000;
  localparam int LIMP3_DUTY_PCT  = 10;
  localparam int LIMP4_FREQ_CHZ  = 125;
  localparam int LIMP4_DUTY_PCT  = 50;
  localparam int LIMP3_PERIOD_TK = 100000 * TICKS_PER_MS / LIMP3_FREQ_CHZ;
  localparam int LIMP4_PERIOD_TK = 100000 * TICKS_PER_MS / LIMP4_FREQ_CHZ;
  localparam int LIMP3_ON_TK     = LIMP3_PERIOD_TK * LIMP3_DUTY_PCT / 100;
  localparam int LIMP4_ON_TK     = LIMP4_PERIOD_TK * LIMP4_DUTY_PCT / 100;

  typedef logic [15:0] hvct_ticks_t;

  // Selectable periods in milliseconds, indexed by the period field.
  localparam int PERIOD_MS [12] = '{4, 8, 20, 30, 50, 100, 200, 400, 800, 1000, 2000, 4000};
  localparam logic [3:0] PERIOD_CODE_MAX = 4'hb;

endpackage

// [design/hvct_chan.sv]
`timescale 1ns/1ps
module hvct_chan
  import hvct_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        tick,
  input  wire logic        restart,
  input  wire logic        slave,
  input  wire logic        delay_first,
  input  wire logic        trig,
  input  wire hvct_ticks_t period,
  input  wire hvct_ticks_t on_ticks,
  output logic             out,
  output logic             start_evt,
  output logic             end_evt
);

  localparam hvct_ticks_t IDLE_CNT = 16'hffff;

  hvct_ticks_t cnt_r;
  hvct_ticks_t cnt_nxt;
  logic        armed_r;
  logic        seen_r;
  logic        wrap;
  logic        active;
  logic        full_on;

  assign full_on = (on_ticks >= period);
  assign wrap    = !restart && !slave && tick && (cnt_r >= period - 16'h0001);
  assign active  = armed_r || !delay_first || slave;

  // ==========================================================================
  // Counter
  // ==========================================================================
  always_comb
  begin
    if (restart)
      cnt_nxt = slave ? IDLE_CNT : '0;
    else if (slave)
    begin
      if (trig)
        cnt_nxt = '0;
      else if (tick && cnt_r != IDLE_CNT)
        cnt_nxt = cnt_r + 16'h0001;
      else
        cnt_nxt = cnt_r;
    end
    else if (tick)
      cnt_nxt = wrap ? '0 : cnt_r + 16'h0001;
    else
      cnt_nxt = cnt_r;
  end

  // Start and end events feed the next timer in the chain in the same cycle.
  always_comb
  begin
    if (restart)
    begin
      start_evt = 1'b0;
      end_evt   = 1'b0;
    end
    else if (slave)
    begin
      start_evt = trig;
      end_evt   = (trig && on_ticks == '0) ||
                  (!trig && tick && cnt_r < on_ticks && cnt_nxt == on_ticks);
    end
    else
    begin
      start_evt = wrap && active;
      end_evt   = tick && active && (cnt_nxt == on_ticks);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_r <= IDLE_CNT;
    else
      cnt_r <= cnt_nxt;
  end

  // The delayed activation waits for the first full period after a restart.
  always_ff @(posedge clk)
  begin
    if (reset || restart)
      armed_r <= 1'b0;
    else if (wrap)
      armed_r <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset || restart)
      seen_r <= 1'b0;
    else if (slave && trig)
      seen_r <= 1'b1;
  end

  // ==========================================================================
  // Output
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (reset || restart)
      out <= 1'b0;
    else if (slave)
      out <= full_on ? (seen_r || trig) : (cnt_nxt < on_ticks); // RULE_16
    else
      out <= (armed_r || wrap || !delay_first) && (full_on || cnt_nxt < on_ticks); // RULE_11 RULE_14
  end

endmodule

// [design/hvct_top.sv]
// Overview of operation
// [RULE_01] A set high-side force-off bit keeps that pin's high-side driver off.
// [RULE_02] A set low-side force-off bit keeps that pin's low-side driver off.
// [RULE_03] Force-off bytes are protected; writes need a prior unlock.
// [RULE_04] Low-side force-off bits 7..0 serve pins 8..1, preset zero.
// [RULE_05] Four timers; any pin may select any timer.
// [RULE_06] Autonomous modes take the period from the timer's own period field.
// [RULE_07] Slave modes ignore their own period and inherit one up the chain.
// [RULE_08] Timer 1 is chain master and has no slave mode.
// [RULE_09] Mode field: 00 PWM, 01 timer, 10 synchronous, 11 follower.
// [RULE_10] Autonomous modes take on-time from the duty field.
// [RULE_11] Timer mode delays pin activation by one full period.
// [RULE_12] PWM duty is a fraction of the selected period.
// [RULE_13] Timer mode pulse width is duty times 100 us.
// [RULE_14] Timer mode output stays on when on-time exceeds the period.
// [RULE_15] Synchronous mode starts with Timer 1 pulse, 100 us steps.
// [RULE_16] Synchronous output stays on when its pulse outlasts the period.
// [RULE_17] Slave modes exist only on Timers 2 to 4.
// [RULE_18] Slaves still trigger when Timer 1 runs at zero duty.
// [RULE_19] Follower starts when the previous pulse ends, inheriting its period.
// [RULE_20] Pin 3 limp-home: Timer 3 gives 100 Hz 10 % and ignores settings.
// [RULE_21] During pin 3 limp-home, other pins on Timer 3 stay off.
// [RULE_22] Pin 4 limp-home: Timer 4 gives 1.25 Hz 50 % only.
// [RULE_23] PWM on-time equals duty times period divided by 255.
// [RULE_24] Duty field is eight bits; duty equals value over 255.
// [RULE_25] Timer mode on-time is duty times base time; period from field.
// [RULE_26] Period field decodes to fixed durations on a shared time base.
`timescale 1ns/1ps
module hvct_top
  import hvct_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input  wire logic                    CLK,
  input  wire logic                    RESET,
  input  wire hvct_pkg::hvct_bus_req_t REQ,
  output logic [7:0]                   RDATA,
  output logic [7:0]                   HS_ON,
  output logic [7:0]                   LS_ON,
  output logic [3:0]                   TIMER_OUT
);

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  function automatic hvct_ticks_t period_ticks(input logic [3:0] code);
    logic [3:0] idx;
    idx = (code > PERIOD_CODE_MAX) ? PERIOD_CODE_MAX : code;
    period_ticks = 16'(PERIOD_MS[idx] * TICKS_PER_MS); // RULE_26
  endfunction

  function automatic hvct_ticks_t pwm_on(input logic [7:0] duty, input hvct_ticks_t per);
    logic [23:0] prod;
    prod   = 24'(duty) * 24'(per);
    pwm_on = 16'(prod / 24'(PWM_FULL_SCALE)); // RULE_23 RULE_24 RULE_12
  endfunction

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] target);
    is_addr = (a == target);
  endfunction

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [CTRL_WIDTH-1:0]     tmr_ctrl_r [NUM_TIMERS];
  logic [7:0]                tmr_duty_r [NUM_TIMERS];
  logic [PIN_CTRL_WIDTH-1:0] pin_ctrl_r [NUM_PINS];
  logic [1:0]                limp_r;
  logic [1:0]                limp_prev_r;
  logic [7:0]                hs_off_r;
  logic [7:0]                ls_off_r;
  logic                      unlock_r;
  logic [15:0]               tick_cnt_r;
  logic                      tick;
  logic [3:0]                restart_r;

  logic                      in_tmr;
  logic [2:0]                tmr_word;
  logic                      in_pin;

  assign in_tmr   = (REQ.addr >= ADDR_TMR_CTRL_BASE) && (REQ.addr <= ADDR_TMR_LAST);
  assign tmr_word = 3'(REQ.addr - ADDR_TMR_CTRL_BASE);
  assign in_pin   = (REQ.addr >= ADDR_PIN_CTRL_BASE) && (REQ.addr <= ADDR_PIN_CTRL_LAST);

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        tmr_ctrl_r[i] <= '0;
        tmr_duty_r[i] <= '0;
      end
    end
    else if (REQ.wr && in_tmr)
    begin
      if (tmr_word[0] == 1'b0)
        tmr_ctrl_r[tmr_word[2:1]] <= REQ.wdata[CTRL_WIDTH-1:0];
      else
        tmr_duty_r[tmr_word[2:1]] <= REQ.wdata;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      for (int i = 0; i < NUM_PINS; i++)
        pin_ctrl_r[i] <= '0;
    end
    else if (REQ.wr && in_pin)
      pin_ctrl_r[REQ.addr[2:0]] <= REQ.wdata[PIN_CTRL_WIDTH-1:0];
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      limp_r <= '0;
    else if (REQ.wr && is_addr(REQ.addr, ADDR_LIMP_HOME))
      limp_r <= REQ.wdata[1:0];
  end

  // The protected bytes accept only the write that directly follows the key.
  always_ff @(posedge CLK)
  begin
    if (RESET)
      unlock_r <= 1'b0;
    else if (REQ.wr)
      unlock_r <= is_addr(REQ.addr, ADDR_NV_UNLOCK) && (REQ.wdata == NV_UNLOCK_KEY); // RULE_03
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      hs_off_r <= FORCE_OFF_PRESET;
      ls_off_r <= FORCE_OFF_PRESET; // RULE_04
    end
    else if (REQ.wr && unlock_r)
    begin
      if (is_addr(REQ.addr, ADDR_HS_FORCE_OFF))
        hs_off_r <= REQ.wdata; // RULE_03
      if (is_addr(REQ.addr, ADDR_LS_FORCE_OFF))
        ls_off_r <= REQ.wdata; // RULE_03
    end
  end

  // A timer restarts when its control register is written or, for Timers 3 and 4, when its own limp-home bit changes.
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      restart_r   <= '1;
      limp_prev_r <= '0;
    end
    else
    begin
      limp_prev_r <= limp_r;
      for (int i = 0; i < NUM_TIMERS; i++)
        restart_r[i] <= (REQ.wr && in_tmr && tmr_word == 3'(2 * i)) ||
                        (i == LIMP3_TMR_IDX && limp_r[LIMP_PIN3_BIT] != limp_prev_r[LIMP_PIN3_BIT]) ||
                        (i == LIMP4_TMR_IDX && limp_r[LIMP_PIN4_BIT] != limp_prev_r[LIMP_PIN4_BIT]);
    end
  end

  // ==========================================================================
  // Shared 100 us time base
  // ==========================================================================
  assign tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));

  always_ff @(posedge CLK)
  begin
    if (RESET || tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 16'h0001; // RULE_26
  end

  // ==========================================================================
  // Per-timer configuration and chaining
  // ==========================================================================
  hvct_mode_t  mode     [NUM_TIMERS];
  logic        limp_on  [NUM_TIMERS];
  logic        slave    [NUM_TIMERS];
  logic        delay_f  [NUM_TIMERS];
  hvct_ticks_t own_per  [NUM_TIMERS];
  hvct_ticks_t eff_per  [NUM_TIMERS];
  hvct_ticks_t on_tk    [NUM_TIMERS];
  logic        trig     [NUM_TIMERS];
  logic        tmr_out  [NUM_TIMERS];
  logic        t_start  [NUM_TIMERS];
  logic        t_end    [NUM_TIMERS];

  always_comb
  begin
    for (int i = 0; i < NUM_TIMERS; i++)
    begin
      mode[i] = hvct_mode_t'(tmr_ctrl_r[i][CTRL_MODE_LSB +: 2]); // RULE_09
      if (i == 0)
        mode[i] = hvct_mode_t'({1'b0, tmr_ctrl_r[i][CTRL_MODE_LSB]}); // RULE_08 RULE_17
      limp_on[i] = (i == LIMP3_TMR_IDX && limp_r[LIMP_PIN3_BIT]) ||
                   (i == LIMP4_TMR_IDX && limp_r[LIMP_PIN4_BIT]);
      own_per[i] = period_ticks(tmr_ctrl_r[i][CTRL_PERIOD_LSB +: 4]); // RULE_06
      slave[i]   = 1'b0;
      delay_f[i] = 1'b0;
      eff_per[i] = own_per[i];
      on_tk[i]   = 16'(tmr_duty_r[i]); // RULE_10 RULE_13 RULE_25
      if (limp_on[i] && i == LIMP3_TMR_IDX)
      begin
        eff_per[i] = 16'(LIMP3_PERIOD_TK); // RULE_20
        on_tk[i]   = 16'(LIMP3_ON_TK); // RULE_20
      end
      else if (limp_on[i])
      begin
        eff_per[i] = 16'(LIMP4_PERIOD_TK); // RULE_22
        on_tk[i]   = 16'(LIMP4_ON_TK); // RULE_22
      end
      else
      begin
        case (mode[i])
          MODE_PWM:
            on_tk[i] = pwm_on(tmr_duty_r[i], own_per[i]); // RULE_12
          MODE_TIMER:
            delay_f[i] = 1'b1; // RULE_11
          MODE_SYNC:
          begin
            slave[i]   = 1'b1;
            eff_per[i] = eff_per[0]; // RULE_07 RULE_15
          end
          MODE_FOLLOWER:
          begin
            slave[i]   = 1'b1;
            eff_per[i] = (i > 0) ? eff_per[(i > 0) ? i - 1 : 0] : own_per[i]; // RULE_19
          end
          default:
            on_tk[i] = '0;
        endcase
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++)
    begin : g_tmr
      if (g == 0)
      begin : g_master
        assign trig[g] = 1'b0;
      end
      else
      begin : g_slave
        // Timer 1 start fires on each period wrap independent of its duty, except the first wrap in timer mode.
        assign trig[g] = (mode[g] == MODE_SYNC) ? t_start[0] : t_end[g-1]; // RULE_15 RULE_18 RULE_19
      end

      hvct_chan u_chan (
        .clk         (CLK),
        .reset       (RESET),
        .tick        (tick),
        .restart     (restart_r[g]),
        .slave       (slave[g]),
        .delay_first (delay_f[g]),
        .trig        (trig[g]),
        .period      (eff_per[g]),
        .on_ticks    (on_tk[g]),
        .out         (tmr_out[g]),
        .start_evt   (t_start[g]),
        .end_evt     (t_end[g])
      ); // RULE_05
    end
  endgenerate

  // ==========================================================================
  // Pin drive
  // ==========================================================================
  logic [7:0] hs_req;
  logic [7:0] ls_req;

  always_comb
  begin
    for (int p = 0; p < NUM_PINS; p++)
    begin
      logic [1:0] sel;
      logic       gate;
      logic       on;
      sel  = pin_ctrl_r[p][PIN_TSEL_LSB +: 2];
      gate = pin_ctrl_r[p][PIN_GATE_BIT];
      on   = !gate || tmr_out[sel]; // RULE_05
      if (gate && limp_on[sel])
        on = 1'b0; // RULE_21 RULE_22
      hs_req[p] = on && (hvct_drive_t'(pin_ctrl_r[p][PIN_DRIVE_LSB +: 2]) == DRIVE_HIGH);
      ls_req[p] = on && (hvct_drive_t'(pin_ctrl_r[p][PIN_DRIVE_LSB +: 2]) == DRIVE_LOW);
      if (p == LIMP3_PIN_IDX && limp_r[LIMP_PIN3_BIT])
      begin
        hs_req[p] = tmr_out[LIMP3_TMR_IDX]; // RULE_20
        ls_req[p] = 1'b0;
      end
      if (p == LIMP4_PIN_IDX && limp_r[LIMP_PIN4_BIT])
      begin
        hs_req[p] = tmr_out[LIMP4_TMR_IDX]; // RULE_22
        ls_req[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      HS_ON     <= '0;
      LS_ON     <= '0;
      TIMER_OUT <= '0;
    end
    else
    begin
      HS_ON <= hs_req & ~hs_off_r; // RULE_01
      LS_ON <= ls_req & ~ls_off_r; // RULE_02 RULE_04
      for (int i = 0; i < NUM_TIMERS; i++)
        TIMER_OUT[i] <= tmr_out[i];
    end
  end

  // ==========================================================================
  // Read port
  // ==========================================================================
  logic [7:0] rd_mux;

  always_comb
  begin
    rd_mux = '0;
    if (in_tmr)
    begin
      if (tmr_word[0] == 1'b0)
      begin
        rd_mux = 8'(tmr_ctrl_r[tmr_word[2:1]]);
        if (tmr_word[2:1] == 2'b00)
          rd_mux[CTRL_MODE_LSB + 1] = 1'b0;
      end
      else
        rd_mux = tmr_duty_r[tmr_word[2:1]];
    end
    else if (in_pin)
      rd_mux = 8'(pin_ctrl_r[REQ.addr[2:0]]);
    else if (is_addr(REQ.addr, ADDR_LIMP_HOME))
      rd_mux = 8'(limp_r);
    else if (is_addr(REQ.addr, ADDR_TMR_STATUS))
      rd_mux = {4'h0, tmr_out[3], tmr_out[2], tmr_out[1], tmr_out[0]};
    else if (is_addr(REQ.addr, ADDR_NV_UNLOCK))
      rd_mux = {7'h00, unlock_r};
    else if (is_addr(REQ.addr, ADDR_HS_FORCE_OFF))
      rd_mux = hs_off_r;
    else if (is_addr(REQ.addr, ADDR_LS_FORCE_OFF))
      rd_mux = ls_off_r;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      RDATA <= '0;
    else if (REQ.rd)
      RDATA <= rd_mux;
    else
      RDATA <= '0;
  end

endmodule

// [tb/hvct_monitor.sv]
`timescale 1ns/1ps
module hvct_monitor
  import hvct_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input wire logic                    CLK,
  input wire logic                    RESET,
  input wire hvct_pkg::hvct_bus_req_t REQ,
  input wire logic [7:0]              RDATA,
  input wire logic [7:0]              HS_ON,
  input wire logic [7:0]              LS_ON,
  input wire logic [3:0]              TIMER_OUT
);
  // ==========================================================================
  // Shadow of the protected bytes
  // ==========================================================================
  logic       armed_r;
  logic [7:0] hs_sh_r;
  logic [7:0] ls_sh_r;

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      armed_r <= 1'b0;
      hs_sh_r <= FORCE_OFF_PRESET;
      ls_sh_r <= FORCE_OFF_PRESET;
    end
    else if (REQ.wr)
    begin
      armed_r <= (REQ.addr == ADDR_NV_UNLOCK) && (REQ.wdata == NV_UNLOCK_KEY);
      if (armed_r && (REQ.addr == ADDR_HS_FORCE_OFF))
        hs_sh_r <= REQ.wdata;
      if (armed_r && (REQ.addr == ADDR_LS_FORCE_OFF))
        ls_sh_r <= REQ.wdata;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence hs_rd_s; REQ.rd && (REQ.addr == ADDR_HS_FORCE_OFF); endsequence
  sequence ls_rd_s; REQ.rd && (REQ.addr == ADDR_LS_FORCE_OFF); endsequence
  sequence t1_rd_s; REQ.rd && (REQ.addr == ADDR_TMR_CTRL_BASE); endsequence
  sequence ctrl_rd_s; REQ.rd && (REQ.addr >= ADDR_TMR_CTRL_BASE) && (REQ.addr <= ADDR_TMR_LAST) && !REQ.addr[0];
  endsequence

  hs_force_a: assert property ((HS_ON & hs_sh_r & $past(hs_sh_r)) == 8'h00)
    else $error("high side driver on while forced off");
  ls_force_a: assert property ((LS_ON & ls_sh_r & $past(ls_sh_r)) == 8'h00)
    else $error("low side driver on while forced off");
  hs_readback_a: assert property (hs_rd_s |=> RDATA == hs_sh_r)
    else $error("high side force byte reads wrong");
  ls_readback_a: assert property (ls_rd_s |=> RDATA == ls_sh_r)
    else $error("low side force byte reads wrong");
  t1_ctrl_a: assert property (t1_rd_s |=> (RDATA[7:6] == 2'b00) && !RDATA[1])
    else $error("timer 1 control shows a slave mode bit");
  ctrl_rsvd_a: assert property (ctrl_rd_s |=> RDATA[7:6] == 2'b00)
    else $error("timer control reserved bits set");
  rdata_idle_a: assert property (!$past(REQ.rd) |-> RDATA == 8'h00)
    else $error("read data outside read answer");
  unmapped_rd_a: assert property (REQ.rd && ((REQ.addr < ADDR_TMR_CTRL_BASE) || (REQ.addr > ADDR_LS_FORCE_OFF))
    |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property ($past(RESET) |-> (HS_ON == 8'h00) && (LS_ON == 8'h00) && (TIMER_OUT == 4'h0))
    else $error("outputs active after reset");
endmodule

bind hvct_top hvct_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.CLK(CLK), .RESET(RESET), .REQ(REQ), .RDATA(RDATA),
  .HS_ON(HS_ON), .LS_ON(LS_ON), .TIMER_OUT(TIMER_OUT));

// [tb/hvct_load_model.sv]
`timescale 1ns/1ps
module hvct_load_model
(
  input wire logic       clk,
  input wire logic [7:0] hs_on,
  input wire logic [7:0] ls_on,
  output logic [7:0]     level,
  output logic           fault_r
);
  // A pin driven by neither side is pulled to ground by its load.
  assign level = hs_on & ~ls_on;

  // Both drivers of one pin on at once would short the supply; the flag is sticky.
  initial fault_r = 1'b0;
  always @(posedge clk)
  begin
    if (|(hs_on & ls_on))
      fault_r <= 1'b1;
  end
endmodule

// [tb/hvct_top_tb.sv]
`timescale 1ns/1ps
module hvct_top_tb;
  import hvct_pkg::*;
  localparam int TK = 4;
  localparam int PER = 40 * TK;
  logic          clk;
  logic          reset;
  hvct_bus_req_t req;
  logic [7:0]    rdata;
  logic [7:0]    hs_on;
  logic [7:0]    ls_on;
  logic [7:0]    level;
  logic [3:0]    tmr_out;
  logic          fault;
  logic [7:0]    rv;
  logic [7:0]    v;
  int            err_count;
  int            checks;
  int            seed;
  int            c[13];
  int            d;
  int            pt;

  hvct_top #(.TICK_CYCLES(TK)) u_dut (.CLK(clk), .RESET(reset), .REQ(req), .RDATA(rdata), .HS_ON(hs_on),
    .LS_ON(ls_on), .TIMER_OUT(tmr_out));
  hvct_load_model u_load (.clk(clk), .hs_on(hs_on), .ls_on(ls_on), .level(level), .fault_r(fault));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task conclude;
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] dt);
    @(posedge clk);
    req <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    q = rdata;
  endtask

  task nv(input logic [7:0] a, input logic [7:0] dt);
    wr(ADDR_NV_UNLOCK, NV_UNLOCK_KEY);
    wr(a, dt);
  endtask

  // Counts high cycles of each timer output, each pin level and the timer 3/4 overlap.
  task meas(input int n);
    for (int i = 0; i < 13; i++)
      c[i] = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++)
        c[i] += tmr_out[i];
      for (int i = 0; i < 8; i++)
        c[4 + i] += level[i];
      c[12] += tmr_out[2] & tmr_out[3];
    end
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  // ==========================================================================
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    repeat (90000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial
  begin
    seed = 72394;
    err_count = 0;
    checks = 0;
    req = '0;
    reset = 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_HS_FORCE_OFF, rv); chk("hs preset", FORCE_OFF_PRESET, rv);
    rd(ADDR_LS_FORCE_OFF, rv); chk("ls preset", FORCE_OFF_PRESET, rv);
    wr(8'h90, 8'h5a); rd(8'h90, rv); chk("unmapped", 8'h00, rv);
    wr(ADDR_LS_FORCE_OFF, 8'hff); rd(ADDR_LS_FORCE_OFF, rv); chk("locked", 8'h00, rv);
    wr(ADDR_NV_UNLOCK, NV_UNLOCK_KEY); wr(ADDR_PIN_CTRL_BASE, 8'h00);
    wr(ADDR_LS_FORCE_OFF, 8'hff); rd(ADDR_LS_FORCE_OFF, rv); chk("stale unlock", 8'h00, rv);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h52, 8'hc0 | m); rd(8'h52, rv); chk("t2 mode", m, rv);
    end
    wr(ADDR_TMR_CTRL_BASE, 8'hff); rd(ADDR_TMR_CTRL_BASE, rv); chk("t1 mode", 8'h3d, rv);
    for (int p = 0; p < 8; p++) wr(ADDR_PIN_CTRL_BASE + p, 8'h02);
    for (int p = 0; p < 8; p++)
    begin
      v = 8'h01 << p;
      nv(ADDR_LS_FORCE_OFF, v); repeat (3) @(posedge clk); #1;
      chk("ls mask", 8'(~v), ls_on);
    end
    for (int p = 0; p < 8; p++) wr(ADDR_PIN_CTRL_BASE + p, 8'h01);
    for (int k = 0; k < 6; k++)
    begin
      v = $random(seed);
      nv(ADDR_HS_FORCE_OFF, v); repeat (3) @(posedge clk); #1;
      chk("hs mask", 8'(~v), hs_on);
      rd(ADDR_HS_FORCE_OFF, rv); chk("hs back", v, rv);
    end
    nv(ADDR_HS_FORCE_OFF, 8'h00); nv(ADDR_LS_FORCE_OFF, 8'h00);
    for (int p = 0; p < 8; p++) wr(ADDR_PIN_CTRL_BASE + p, 8'h00);
    wr(ADDR_PIN_CTRL_BASE, 8'h05); wr(8'h61, 8'h0d);
    for (int k = 0; k < 4; k++)
    begin
      d = (k == 0) ? 0 : (k == 1) ? 255 : ($random(seed) & 255);
      pt = PERIOD_MS[k % 2] * TICKS_PER_MS;
      wr(8'h51, d); wr(ADDR_TMR_CTRL_BASE, (k % 2) << 2);
      repeat (pt * TK) @(posedge clk);
      meas(2 * pt * TK);
      chk("pwm on", 2 * (d * pt / 255) * TK, c[0]);
      chk("pin1 level", c[0], c[4]);
    end
    wr(8'h52, 8'h01); wr(8'h53, 10);
    meas(PER - 8); chk("first period", 0, c[1] + c[5]);
    repeat (16) @(posedge clk);
    meas(2 * PER); chk("timer on", 2 * 10 * TK, c[1]);
    wr(8'h53, 50); repeat (PER) @(posedge clk);
    meas(PER); chk("timer full", PER, c[1]);
    wr(ADDR_TMR_CTRL_BASE, 8'h00); wr(8'h51, 0);
    wr(8'h55, 5); wr(8'h54, 8'h06); wr(8'h57, 7); wr(8'h56, 8'h07);
    repeat (2 * PER) @(posedge clk);
    meas(2 * PER);
    chk("sync on", 2 * 5 * TK, c[2]);
    chk("follower on", 2 * 7 * TK, c[3]);
    chk("overlap", 0, c[12]);
    wr(8'h55, 60); repeat (PER) @(posedge clk);
    meas(2 * PER); chk("sync full", 2 * PER, c[2]);
    wr(8'h64, 8'h15); wr(ADDR_LIMP_HOME, 8'h03); wr(8'h54, 8'h01);
    repeat (8) @(posedge clk);
    meas(LIMP4_PERIOD_TK * TK);
    chk("limp3 clock", (LIMP4_PERIOD_TK / LIMP3_PERIOD_TK) * LIMP3_ON_TK * TK, c[6]);
    chk("limp3 others", 0, c[8]);
    chk("limp4 clock", LIMP4_ON_TK * TK, c[3]);
    chk("short", 1'b0, fault);
    conclude();
  end
endmodule
